/* File: src/rap_region_check.sv */
`timescale 1ns/1ps
module rap_region_check
	import rap_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire rap_cfg_t    i_cfg,
	input  wire logic [31:0] i_attribute_table_low,
	input  wire logic [31:0] i_attribute_table_high,
	input  wire logic        i_unit_enable,
	input  wire rap_access_t i_access,
	output logic [7:0]       o_region_select_reg,
	output logic [31:0]      o_region_base_reg,
	output logic [31:0]      o_region_limit_reg,
	output rap_result_t      o_result,
	output logic             o_memory_management_fault
);

	typedef struct packed {
		logic [NUM_REGIONS-1:0][31:0] base;
		logic [NUM_REGIONS-1:0][31:0] limit;
		logic [7:0]                   select;
		rap_result_t                  result;
		logic                         fault;
		logic [31:0]                  base_rd;
		logic [31:0]                  limit_rd;
	} rap_state_t;

	rap_state_t state_ff;
	rap_state_t nxt_state;

	// Only eight regions exist, so the upper select bits never index an entry
	function automatic logic [2:0] region_slot(input logic [7:0] sel);
		return sel[2:0];
	endfunction

	// Outer and inner nibbles share one encoding; all zeros only matters inner
	function automatic rap_cache_kind_t decode_nibble(input logic [3:0] nib, input logic is_outer);
		rap_cache_kind_t k;
		k = CACHE_UNPREDICTABLE;
		if (nib == NONCACHE_NIBBLE) begin
			k = CACHE_NONE;
		end else if (nib == DEVICE_NIBBLE) begin
			k = CACHE_UNPREDICTABLE;
		end else begin
			case (nib[3:2])
				2'h0: k = CACHE_WT_TRANSIENT;
				2'h1: k = CACHE_WB_TRANSIENT;
				2'h2: k = CACHE_WT_NON_TRANSIENT;
				default: k = CACHE_WB_NON_TRANSIENT;
			endcase
		end
		if (is_outer && nib == DEVICE_NIBBLE) begin
			k = CACHE_NONE;
		end
		return k;
	endfunction

	// Allocation hints only mean something for a cacheable nibble
	function automatic rap_attr_dec_t decode_attr(input logic [7:0] memory_attribute_byte);
		rap_attr_dec_t d;
		logic cacheable_o;
		logic cacheable_i;
		d = '0;
		cacheable_o = memory_attribute_byte[7:4] != NONCACHE_NIBBLE;
		cacheable_i = memory_attribute_byte[3:0] != NONCACHE_NIBBLE;
		if (memory_attribute_byte[7:4] == DEVICE_NIBBLE) begin
			d.is_device   = 1'b1;
			d.device_kind = rap_device_kind_t'(memory_attribute_byte[3:2]);
			d.outer_kind  = CACHE_NONE;
			d.inner_kind  = CACHE_NONE;
		end else begin
			d.outer_kind        = decode_nibble(memory_attribute_byte[7:4], 1'b1);
			d.inner_kind        = decode_nibble(memory_attribute_byte[3:0], 1'b0);
			d.outer_read_alloc  = cacheable_o & memory_attribute_byte[5];
			d.outer_write_alloc = cacheable_o & memory_attribute_byte[4];
			d.inner_read_alloc  = cacheable_i & memory_attribute_byte[1];
			d.inner_write_alloc = cacheable_i & memory_attribute_byte[0];
		end
		return d;
	endfunction

	// Privilege and write rights come from the two AP bits; XN only stops fetches
	function automatic logic perm_ok(input logic [1:0] ap, input logic xn, input rap_access_t a);
		logic ok;
		ok = 1'b1;
		case (ap)
			AP_PRIV_RW: begin
				ok = a.privileged;
			end
			AP_ANY_RW: begin
				ok = 1'b1;
			end
			AP_PRIV_RO: begin
				ok = a.privileged && !a.write;
			end
			default: begin
				ok = !a.write;
			end
		endcase
		if (a.fetch && xn) begin
			ok = 1'b0;
		end
		return ok;
	endfunction

	// Inclusive window: base padded with zeros, limit padded with ones
	function automatic logic in_region(input logic [31:0] base, input logic [31:0] limit,
		input logic [31:0] addr);
		logic [31:0] lo;
		logic [31:0] hi;
		lo = {base[31:BASE_ADDR_LSB], 5'h00};
		hi = {limit[31:LIM_ADDR_LSB], LIMIT_LOW_FILL};
		return limit[LIM_EN_BIT] && addr >= lo && addr <= hi;
	endfunction

	logic [NUM_REGIONS-1:0] hit_vec;
	logic [63:0]            attr_table;

	assign attr_table = {i_attribute_table_high, i_attribute_table_low};

	genvar g;
	generate
		for (g = 0; g < NUM_REGIONS; g++) begin : g_hit
			assign hit_vec[g] = in_region(state_ff.base[g], state_ff.limit[g], i_access.addr);
		end
	endgenerate

	always_comb begin
		logic [2:0]  idx;
		logic [2:0]  attr_idx;
		logic        found;
		logic [31:0] b;
		logic [31:0] l;
		idx = '0;
		attr_idx = '0;
		found = 1'b0;
		b = '0;
		l = '0;
		nxt_state = state_ff;
		if (i_cfg.write_sel) begin
			nxt_state.select = i_cfg.select;
		end
		if (i_cfg.write_base) begin
			nxt_state.base[region_slot(state_ff.select)] = i_cfg.base;
		end
		// Reserved bit 4 of the limit is never stored, so it reads back as zero
		if (i_cfg.write_limit) begin
			nxt_state.limit[region_slot(state_ff.select)] = {i_cfg.limit[31:LIM_ADDR_LSB], 1'b0,
				i_cfg.limit[LIM_ADDR_LSB-2:0]};
		end
		// Highest numbered matching region wins
		for (int i = 0; i < NUM_REGIONS; i++) begin
			if (hit_vec[i]) begin
				idx = 3'(i);
				found = 1'b1;
			end
		end
		b = state_ff.base[idx];
		l = state_ff.limit[idx];
		attr_idx = l[LIM_IDX_LSB +: 3];
		nxt_state.result = '0;
		nxt_state.fault = 1'b0;
		if (i_access.valid) begin
			nxt_state.result.valid  = 1'b1;
			nxt_state.result.hit    = found;
			nxt_state.result.region = idx;
			if (found) begin
				nxt_state.result.attr = decode_attr(attr_table[attr_idx*8 +: 8]);
				nxt_state.result.global_monitor = i_access.exclusive &&
					(b[BASE_SH_LSB +: 2] != SH_NONE);
				nxt_state.fault = i_unit_enable &&
					!perm_ok(b[BASE_AP_LSB +: 2], b[BASE_XN_BIT], i_access);
			end else begin
				// No region matched: fault when the unit is enabled
				nxt_state.fault = i_unit_enable;
			end
			nxt_state.result.fault = nxt_state.fault;
		end
		// Readback copies follow the select value that stands next cycle
		nxt_state.base_rd  = nxt_state.base[region_slot(nxt_state.select)];
		nxt_state.limit_rd = nxt_state.limit[region_slot(nxt_state.select)];
	end

	// One register holds all state, so reset clears every output at once
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Every output is a plain copy of a state flop
	assign o_region_select_reg       = state_ff.select;
	assign o_region_base_reg         = state_ff.base_rd;
	assign o_region_limit_reg        = state_ff.limit_rd;
	assign o_result                  = state_ff.result;
	assign o_memory_management_fault = state_ff.fault;

endmodule // rap_region_check

/* File: inc/rap_pkg.sv */
package rap_pkg;

	localparam int NUM_REGIONS = 8;
	localparam int NUM_ATTR    = 8;

	localparam logic [3:0] DEVICE_NIBBLE  = 4'h0;
	localparam logic [3:0] NONCACHE_NIBBLE = 4'h4;
	localparam logic [4:0] LIMIT_LOW_FILL = 5'h1F;

	localparam int LIM_EN_BIT    = 0;
	localparam int LIM_IDX_LSB   = 1;
	localparam int LIM_ADDR_LSB  = 5;
	localparam int BASE_XN_BIT   = 0;
	localparam int BASE_AP_LSB   = 1;
	localparam int BASE_SH_LSB   = 3;
	localparam int BASE_ADDR_LSB = 5;

	localparam logic [1:0] AP_PRIV_RW = 2'h0;
	localparam logic [1:0] AP_ANY_RW  = 2'h1;
	localparam logic [1:0] AP_PRIV_RO = 2'h2;
	localparam logic [1:0] AP_ANY_RO  = 2'h3;

	localparam logic [1:0] SH_NONE = 2'h0;

	typedef enum logic [1:0] {
		DEV_STRICT,
		DEV_EARLY_ACK,
		DEV_REORDER_EARLY_ACK,
		DEV_GATHER_REORDER_EARLY_ACK
	} rap_device_kind_t;

	typedef enum logic [2:0] {
		CACHE_NONE,
		CACHE_WT_TRANSIENT,
		CACHE_WB_TRANSIENT,
		CACHE_WT_NON_TRANSIENT,
		CACHE_WB_NON_TRANSIENT,
		CACHE_UNPREDICTABLE
	} rap_cache_kind_t;

	typedef struct packed {
		logic             is_device;
		rap_device_kind_t device_kind;
		rap_cache_kind_t  outer_kind;
		logic             outer_read_alloc;
		logic             outer_write_alloc;
		rap_cache_kind_t  inner_kind;
		logic             inner_read_alloc;
		logic             inner_write_alloc;
	} rap_attr_dec_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic        write;
		logic        fetch;
		logic        privileged;
		logic        exclusive;
	} rap_access_t;

	typedef struct packed {
		logic          valid;
		logic          fault;
		logic          hit;
		logic [2:0]    region;
		rap_attr_dec_t attr;
		logic          global_monitor;
	} rap_result_t;

	typedef struct packed {
		logic [7:0]  select;
		logic [31:0] base;
		logic [31:0] limit;
		logic        write_sel;
		logic        write_base;
		logic        write_limit;
	} rap_cfg_t;

endpackage

/* File: dv/rap_asserts.sv */
`timescale 1ns/1ps
module rap_asserts
	import rap_pkg::*;
(
	input wire logic        i_clk,
	input wire logic        i_srst,
	input wire rap_cfg_t    i_cfg,
	input wire logic        i_unit_enable,
	input wire rap_access_t i_access,
	input wire logic [7:0]  o_region_select_reg,
	input wire logic [31:0] o_region_base_reg,
	input wire logic [31:0] o_region_limit_reg,
	input wire rap_result_t o_result,
	input wire logic        o_memory_management_fault
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);

	property p_cause;
		o_memory_management_fault |-> $past(i_access.valid) && $past(i_unit_enable);
	endproperty
	a_cause: assert property (p_cause) else $error("fault without cause");

	property p_match;
		o_memory_management_fault == (o_result.valid && o_result.fault);
	endproperty
	a_match: assert property (p_match) else $error("fault pulse mismatch");

	property p_ans;
		i_access.valid |=> o_result.valid;
	endproperty
	a_ans: assert property (p_ans) else $error("no answer");

	property p_quiet;
		!i_access.valid |=> !o_result.valid;
	endproperty
	a_quiet: assert property (p_quiet) else $error("spurious result");

	property p_gmon;
		o_result.global_monitor |-> o_result.valid && $past(i_access.exclusive);
	endproperty
	a_gmon: assert property (p_gmon) else $error("bad monitor");

	property p_sel;
		i_cfg.write_sel |=> o_region_select_reg == $past(i_cfg.select);
	endproperty
	a_sel: assert property (p_sel) else $error("select lost");

	property p_base;
		i_cfg.write_base && !i_cfg.write_sel |=> o_region_base_reg == $past(i_cfg.base);
	endproperty
	a_base: assert property (p_base) else $error("base lost");

	property p_lim;
		i_cfg.write_limit && !i_cfg.write_sel |=>
			o_region_limit_reg == ($past(i_cfg.limit) & 32'hFFFF_FFEF);
	endproperty
	a_lim: assert property (p_lim) else $error("limit lost");

	c_fault: cover property (o_memory_management_fault);
	c_dev: cover property (o_result.valid && o_result.attr.is_device);
	c_gmon: cover property (o_result.global_monitor);
endmodule // rap_asserts
bind rap_region_check rap_asserts u_chk (
	.i_clk                     (i_clk),
	.i_srst                    (i_srst),
	.i_cfg                     (i_cfg),
	.i_unit_enable             (i_unit_enable),
	.i_access                  (i_access),
	.o_region_select_reg       (o_region_select_reg),
	.o_region_base_reg         (o_region_base_reg),
	.o_region_limit_reg        (o_region_limit_reg),
	.o_result                  (o_result),
	.o_memory_management_fault (o_memory_management_fault)
);

/* File: dv/rap_sw_model.sv */
`timescale 1ns/1ps
module rap_sw_model
	import rap_pkg::*;
(
	input  wire logic  i_clk,
	output rap_cfg_t    o_cfg,
	output rap_access_t o_acc
);
	initial begin
		o_cfg = '0;
		o_acc = '0;
	end
	task automatic wr(input int k, input logic [31:0] v);
		@(posedge i_clk);
		o_cfg <= '{v[7:0], v, v, k == 0, k == 1, k == 2};
	endtask
	task automatic idle;
		@(posedge i_clk);
		o_cfg <= '0;
		#1;
	endtask
	// Select first, then base, then limit, then a quiet cycle as barrier;
	// no access is issued while a region is being changed
	task automatic program_region(input logic [7:0] r, input logic [31:0] b, l);
		wr(0, {24'h0, r});
		wr(1, b);
		wr(2, l);
		idle;
	endtask
	task automatic access(input logic [31:0] a, input logic w, f, p, x);
		@(posedge i_clk);
		o_acc <= '{1'b1, a, w, f, p, x};
		@(posedge i_clk);
		o_acc <= '{1'b0, ~a, ~w, ~f, ~p, ~x};
		#1;
	endtask
endmodule // rap_sw_model

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
	import rap_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_srst = 1'b1;
	logic        i_unit_enable = 1'b1;
	logic [63:0] tbl = {8{8'h44}};
	rap_cfg_t    cfg;
	rap_access_t acc;
	logic [7:0]  sel;
	logic [31:0] base, lim;
	rap_result_t res;
	logic        fault;
	int          n_mismatch = 0, checks = 0, cyc = 0;
	logic [7:0]  attrs [16] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h44, 8'h11, 8'h56, 8'hAA,
		8'hFF, 8'h9B, 8'h72, 8'hE4, 8'h40, 8'h3D, 8'h0D, 8'hC8};
	always #25 i_clk = ~i_clk;
	rap_sw_model sw (.i_clk(i_clk), .o_cfg(cfg), .o_acc(acc));
	rap_region_check dut (.i_clk(i_clk), .i_srst(i_srst), .i_cfg(cfg),
		.i_attribute_table_low(tbl[31:0]), .i_attribute_table_high(tbl[63:32]),
		.i_unit_enable(i_unit_enable), .i_access(acc), .o_region_select_reg(sel),
		.o_region_base_reg(base), .o_region_limit_reg(lim), .o_result(res),
		.o_memory_management_fault(fault));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			give_verdict;
		end
	end
	task automatic chk(input string what, input logic [63:0] exp, got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	function automatic rap_cache_kind_t kind(input logic [3:0] n);
		if (n == NONCACHE_NIBBLE) return CACHE_NONE;
		if (n == 4'h0) return CACHE_UNPREDICTABLE;
		return rap_cache_kind_t'(n[3:2] + 3'h1);
	endfunction
	task automatic acc_chk(input logic [31:0] a, input logic w, f, p, x, ef, eg);
		sw.access(a, w, f, p, x);
		chk("valid", 1'b1, res.valid);
		chk("fault", ef, fault);
		chk("result fault", ef, res.fault);
		chk("monitor", eg, res.global_monitor);
	endtask
	initial begin
		logic [63:0]   t;
		logic [7:0]    b;
		logic [9:0]    exp_n;
		logic [9:0]    got_n;
		rap_attr_dec_t a;
		repeat (3) @(posedge i_clk);
		i_srst <= 1'b0;
		for (int r = 0; r < NUM_REGIONS; r++) begin
			sw.program_region(r[7:0], 32'h0, 32'h0);
		end
		for (int k = 0; k < 16; k++) begin
			b = attrs[k];
			t = {8{8'h44}};
			t[8 * (k % 8) +: 8] = b;
			@(posedge i_clk);
			tbl <= t;
			sw.program_region(8'h0, 32'h1002, {27'hFF, 1'b0, k[2:0], 1'b1});
			sw.access(32'h1800, 1'b0, 1'b0, 1'b0, 1'b0);
			a = res.attr;
			chk("device", b[7:4] == DEVICE_NIBBLE, a.is_device);
			if (b[7:4] == DEVICE_NIBBLE) begin
				chk("subtype", b[3:2], a.device_kind);
			end else begin
				exp_n = {kind(b[7:4]), b[5:4], kind(b[3:0]), b[1:0]};
				got_n = {a.outer_kind, a.outer_read_alloc, a.outer_write_alloc, a.inner_kind,
					a.inner_read_alloc, a.inner_write_alloc};
				chk("normal", exp_n, got_n);
			end
		end
		$display("test attributes done");
		sw.program_region(8'h0, 32'h1015, 32'h1FE1);
		acc_chk(32'h1000, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
		acc_chk(32'h1FFF, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
		acc_chk(32'h1FFF, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		acc_chk(32'h1004, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
		acc_chk(32'h2000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		acc_chk(32'h0FFC, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		@(posedge i_clk);
		i_unit_enable <= 1'b0;
		acc_chk(32'h2000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		acc_chk(32'h1FFF, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		@(posedge i_clk);
		i_unit_enable <= 1'b1;
		sw.program_region(8'h0, 32'h1002, 32'h1FE1);
		acc_chk(32'h1000, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		$display("test permissions done");
		sw.program_region(8'h3, 32'h1802, 32'h1FFF);
		sw.access(32'h1800, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("region", 4'hB, {res.hit, res.region});
		sw.wr(0, 32'h0B);
		sw.idle;
		chk("select", 8'h0B, sel);
		chk("limit", 32'h1FEF, lim);
		chk("base", 32'h1802, base);
		$display("test registers done");
		@(posedge i_clk);
		i_srst <= 1'b1;
		@(posedge i_clk);
		i_srst <= 1'b0;
		#1;
		chk("select after reset", 8'h00, sel);
		chk("limit after reset", 32'h0, lim);
		chk("valid after reset", 1'b0, res.valid);
		$display("test reset done");
		give_verdict;
	end
endmodule // tb
